// [core/ldi2c_defines.svh]
`ifndef LDI2C_DEFINES_SVH
`define LDI2C_DEFINES_SVH
`define LDI2C_ADDR_STRAP0 7'h40
`define LDI2C_ADDR_STRAP1 7'h41
`define LDI2C_REG_COUNT 32
`define LDI2C_IDX_W 5
`define LDI2C_BITS_PER_BYTE 4'h8
`define LDI2C_ACK_SLOT 4'h8
`define LDI2C_SCL_HALF_DIV 16'h0003
`endif

// [core/ldi2c_pkg.sv]
package ldi2c_pkg;
   typedef enum logic [2:0] {
      LDI2C_S_IDLE = 3'b000,
      LDI2C_S_ADDR = 3'b001,
      LDI2C_S_RIDX = 3'b011,
      LDI2C_S_WDAT = 3'b010,
      LDI2C_S_RDAT = 3'b110,
      LDI2C_S_IGN = 3'b111
   } ldi2c_state_t;
   typedef enum logic [3:0] {
      LDI2C_M_IDLE = 4'h0,
      LDI2C_M_START = 4'h1,
      LDI2C_M_BIT_LO = 4'h3,
      LDI2C_M_BIT_HI = 4'h2,
      LDI2C_M_STOP_LO = 4'h6,
      LDI2C_M_STOP_HI = 4'h7,
      LDI2C_M_DONE = 4'h5
   } ldi2c_mstate_t;
endpackage

// [core/ldi2c_if.sv]
`timescale 1ns/1ps
interface ldi2c_if;
   logic scl;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic sda;
   // Open-drain wire: pulled high unless an enabled driver pulls it low.
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
   modport host (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface

// [core/ldi2c_sync.sv]
`timescale 1ns/1ps
module ldi2c_sync import ldi2c_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '1;
         s2_q <= '1;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule

// [core/ldi2c_device.sv]
`timescale 1ns/1ps
`include "ldi2c_defines.svh"
// Functional notes
// - SDA falling while SCL high starts transfer
// - SDA rising while SCL high stops transfer
// - Seven address bits, direction bit, ack slot
// - Data bytes are eight bits plus ack
// - Start or stop resets the sequencer anytime
// - SDA changes only while SCL is low
// - Direction bit low writes, high reads
// - Matching address acknowledged on ninth clock
// - Every written data byte is acknowledged
// - Master releases SDA before ack clock
// - Zero-ohm strap selects address 100 0000
// - Only master drives SCL; SDA open-drain
// - State held as 8-bit register clusters
// - Separate write-side and read-side registers
// - Write: start, address, index, data, stop
// - Further write bytes go to next index
// - Reads stream successive registers until NACK
// - Paired registers written upper byte first
// - Partial byte cut by start/stop discarded
module ldi2c_device import ldi2c_pkg::*; #(
   parameter int NREG = `LDI2C_REG_COUNT
) (
   // Core clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link side, clocked by the bus clock
   ldi2c_if.device bus,
   input wire logic scl_clk,
   // Address strap, low for the zero-ohm resistor
   input wire logic addr_strap,
   // Write-side register file towards internal logic
   output logic wr_stb,
   output logic [`LDI2C_IDX_W-1:0] wr_idx,
   output logic [7:0] wr_data,
   // Read-side register file from internal logic
   output logic [`LDI2C_IDX_W-1:0] rd_idx,
   input wire logic [7:0] rd_data
);
   // ****************************************************************
   // Start and stop detection
   // ****************************************************************
   // SCL is the link clock, so start and stop are seen on SDA edges while the
   // clock is high. Each event flips a toggle that the next SCL rise takes
   // as seen, so no flag has to be cleared from a second clock.
   logic start_tog_q;
   logic stop_tog_q;
   logic start_seen_q;
   logic stop_seen_q;
   logic start_pend;
   logic stop_pend;
   always_ff @(negedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         start_tog_q <= 1'b0;
      end else if (bus.scl) begin
         start_tog_q <= !start_tog_q;
      end
   end
   always_ff @(posedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         stop_tog_q <= 1'b0;
      end else if (bus.scl) begin
         stop_tog_q <= !stop_tog_q;
      end
   end
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end else begin
         start_seen_q <= start_tog_q;
         stop_seen_q <= stop_tog_q;
      end
   end
   assign start_pend = start_tog_q != start_seen_q;
   assign stop_pend = stop_tog_q != stop_seen_q;
   // ****************************************************************
   // Bit sequencer on rising SCL
   // ****************************************************************
   ldi2c_state_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [`LDI2C_IDX_W-1:0] idx_q, idx_d;
   logic rd_ack_q, rd_ack_d;
   logic [7:0] wdat_q, wdat_d;
   logic wtog_q, wtog_d;
   logic [6:0] own_q;
   logic strap_seen_q;
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         own_q <= `LDI2C_ADDR_STRAP0;
         strap_seen_q <= 1'b0;
      end else if (!strap_seen_q) begin
         own_q <= addr_strap ? `LDI2C_ADDR_STRAP1 : `LDI2C_ADDR_STRAP0;
         strap_seen_q <= 1'b1;
      end
   end
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      idx_d = idx_q;
      rd_ack_d = rd_ack_q;
      wdat_d = wdat_q;
      wtog_d = wtog_q;
      if (start_pend) begin
         st_d = LDI2C_S_ADDR;
         bit_d = 4'h1;
         sh_d = {7'h00, bus.sda};
      end else if (stop_pend) begin
         st_d = LDI2C_S_IDLE;
         bit_d = 4'h0;
      end else if (st_q != LDI2C_S_IDLE && st_q != LDI2C_S_IGN) begin
         if (bit_q == `LDI2C_ACK_SLOT) begin
            bit_d = 4'h0;
            if (st_q == LDI2C_S_RDAT) begin
               rd_ack_d = !bus.sda;
            end
         end else begin
            sh_d = {sh_q[6:0], bus.sda};
            bit_d = bit_q + 4'h1;
            if (bit_q == `LDI2C_BITS_PER_BYTE - 4'h1) begin
               case (st_q)
                  LDI2C_S_ADDR: begin
                     if (sh_q[6:0] != own_q) begin
                        st_d = LDI2C_S_IGN;
                     end else if (bus.sda) begin
                        st_d = LDI2C_S_RDAT;
                        rd_ack_d = 1'b1;
                     end else begin
                        st_d = LDI2C_S_RIDX;
                     end
                  end
                  LDI2C_S_RIDX: begin
                     idx_d = {sh_q[`LDI2C_IDX_W-2:0], bus.sda};
                     st_d = LDI2C_S_WDAT;
                  end
                  LDI2C_S_WDAT: begin
                     wdat_d = {sh_q[6:0], bus.sda};
                     wtog_d = !wtog_q;
                     // The hold register takes the old index at this same edge.
                     idx_d = idx_q + 5'h01;
                  end
                  LDI2C_S_RDAT: begin
                     // Stepped here so the next byte loads from the new index.
                     idx_d = idx_q + 5'h01;
                  end
                  default: begin
                     st_d = st_q;
                  end
               endcase
            end
         end
      end
   end
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= LDI2C_S_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         idx_q <= '0;
         rd_ack_q <= 1'b0;
         wdat_q <= 8'h00;
         wtog_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         idx_q <= idx_d;
         rd_ack_q <= rd_ack_d;
         wdat_q <= wdat_d;
         wtog_q <= wtog_d;
      end
   end
   // ****************************************************************
   // SDA drive on falling SCL
   // ****************************************************************
   // Updating only on the falling edge keeps SDA stable while SCL is high.
   logic oe_q, oe_d;
   logic [7:0] tx_q, tx_d;
   logic was_idx_q;
   always_comb begin
      oe_d = 1'b0;
      tx_d = tx_q;
      // In a read only the address slot is ours; after data the master answers.
      if (bit_q == `LDI2C_ACK_SLOT && st_q != LDI2C_S_IGN && st_q != LDI2C_S_IDLE &&
          !(st_q == LDI2C_S_RDAT && was_idx_q)) begin
         oe_d = 1'b1;
      end
      if (st_q == LDI2C_S_RDAT && rd_ack_q && bit_q != `LDI2C_ACK_SLOT) begin
         if (bit_q == 4'h0) begin
            tx_d = rd_data;
         end
         oe_d = !(bit_q == 4'h0 ? rd_data[7] : tx_q[3'h7 - bit_q[2:0]]);
      end
   end
   always_ff @(negedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_q <= 1'b0;
         tx_q <= 8'h00;
         was_idx_q <= 1'b0;
      end else begin
         oe_q <= oe_d && !start_pend && !stop_pend;
         tx_q <= tx_d;
         was_idx_q <= st_q == LDI2C_S_RDAT && bit_q == 4'h7 ? 1'b1 :
            (st_q != LDI2C_S_RDAT ? 1'b0 : was_idx_q);
      end
   end
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = oe_q;
   assign rd_idx = idx_q;
   // ****************************************************************
   // Write strobe crossing into the core domain
   // ****************************************************************
   logic [1:0] tog_s;
   logic tog_q;
   logic [7:0] wd_q;
   logic [`LDI2C_IDX_W-1:0] wi_q;
   logic stb_q;
   logic [`LDI2C_IDX_W-1:0] widx_hold_q;
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         widx_hold_q <= '0;
      end else if (st_q == LDI2C_S_WDAT && bit_q == 4'h7) begin
         widx_hold_q <= idx_q;
      end
   end
   ldi2c_sync #(.W(1)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      // Inverted so the synchroniser's reset level matches and no strobe follows reset.
      .d(!wtog_q),
      .q(tog_s[0])
   );
   assign tog_s[1] = tog_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_q <= 1'b1;
         stb_q <= 1'b0;
         wd_q <= 8'h00;
         wi_q <= '0;
      end else begin
         tog_q <= tog_s[0];
         stb_q <= tog_s[0] != tog_s[1];
         if (tog_s[0] != tog_s[1]) begin
            wd_q <= wdat_q;
            wi_q <= widx_hold_q;
         end
      end
   end
   assign wr_stb = stb_q;
   assign wr_data = wd_q;
   assign wr_idx = wi_q;
endmodule

// [core/ldi2c_host.sv]
`timescale 1ns/1ps
`include "ldi2c_defines.svh"
module ldi2c_host import ldi2c_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link
   ldi2c_if.host bus,
   // Byte command: cmd_start sends a start before the byte, cmd_stop a stop after
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic cmd_read,
   input wire logic cmd_nack,
   input wire logic [7:0] cmd_data,
   // Result
   output logic res_valid,
   output logic [7:0] res_data,
   output logic res_ack
);
   ldi2c_mstate_t st_q, st_d;
   logic [15:0] div_q, div_d;
   logic [3:0] bit_q, bit_d;
   logic [8:0] sh_q, sh_d;
   logic [8:0] rx_q, rx_d;
   logic scl_q, scl_d, sda_q, sda_d, stop_q, stop_d, vld_q, vld_d;
   logic sda_in;
   ldi2c_sync #(.W(1)) u_sync (.clk(clk), .rst_n(rst_n), .d(bus.sda), .q(sda_in));
   // Ready only on the tick the idle state acts, so an accepted command is never lost.
   assign cmd_ready = st_q == LDI2C_M_IDLE && div_q == 16'h0000;
   always_comb begin
      st_d = st_q; div_d = div_q; bit_d = bit_q; sh_d = sh_q; rx_d = rx_q;
      scl_d = scl_q; sda_d = sda_q; stop_d = stop_q; vld_d = 1'b0;
      if (div_q != 16'h0000) begin
         div_d = div_q - 16'h0001;
      end else begin
         div_d = `LDI2C_SCL_HALF_DIV;
         case (st_q)
            LDI2C_M_IDLE: begin
               if (cmd_valid) begin
                  sh_d = {cmd_read ? 8'hff : cmd_data, cmd_read ? cmd_nack : 1'b1};
                  stop_d = cmd_stop;
                  bit_d = 4'h0;
                  st_d = cmd_start ? LDI2C_M_START : LDI2C_M_BIT_LO;
               end
            end
            LDI2C_M_START: begin
               // One step per half period: release SDA, raise SCL, drop SDA, drop SCL.
               // Raising both at once would race the start against a clock edge.
               if (!scl_q && !sda_q) begin
                  sda_d = 1'b1;
               end else if (!scl_q) begin
                  scl_d = 1'b1;
               end else if (sda_q) begin
                  sda_d = 1'b0;
               end else begin
                  scl_d = 1'b0;
                  st_d = LDI2C_M_BIT_LO;
               end
            end
            LDI2C_M_BIT_LO: begin
               scl_d = 1'b0;
               sda_d = sh_q[8];
               st_d = LDI2C_M_BIT_HI;
            end
            LDI2C_M_BIT_HI: begin
               if (!scl_q) begin
                  scl_d = 1'b1;
               end else begin
                  rx_d = {rx_q[7:0], sda_in};
                  sh_d = {sh_q[7:0], 1'b1};
                  scl_d = 1'b0;
                  bit_d = bit_q + 4'h1;
                  st_d = bit_q == `LDI2C_ACK_SLOT ? (stop_q ? LDI2C_M_STOP_LO : LDI2C_M_DONE)
                     : LDI2C_M_BIT_LO;
               end
            end
            LDI2C_M_STOP_LO: begin
               sda_d = 1'b0;
               st_d = LDI2C_M_STOP_HI;
            end
            LDI2C_M_STOP_HI: begin
               if (!scl_q) begin
                  scl_d = 1'b1;
               end else begin
                  sda_d = 1'b1;
                  st_d = LDI2C_M_DONE;
               end
            end
            default: begin
               vld_d = 1'b1;
               st_d = LDI2C_M_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= LDI2C_M_IDLE; div_q <= 16'h0000; bit_q <= 4'h0;
         sh_q <= 9'h1ff; rx_q <= 9'h000; scl_q <= 1'b1; sda_q <= 1'b1;
         stop_q <= 1'b0; vld_q <= 1'b0;
      end else begin
         st_q <= st_d; div_q <= div_d; bit_q <= bit_d; sh_q <= sh_d; rx_q <= rx_d;
         scl_q <= scl_d; sda_q <= sda_d; stop_q <= stop_d; vld_q <= vld_d;
      end
   end
   assign bus.scl = scl_q;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe = !sda_q;
   assign res_valid = vld_q;
   assign res_data = rx_q[8:1];
   assign res_ack = !rx_q[0];
endmodule

// [tb/ldi2c_checker_sva.sv]
`timescale 1ns/1ps
module ldi2c_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link wires and strap
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   input wire logic addr_strap
);
   // ********************
   // Bus decoding
   // ********************
   // The core clock oversamples the link, so bit edges show up as level changes.
   logic scl_q, sda_q, rd_q, hit_q, idle_q;
   logic [3:0] cnt_q;
   logic [1:0] byte_q;
   logic [7:0] sh_q;
   logic start, stop, rise, pull, mpull;
   logic [6:0] own;
   assign own = addr_strap ? 7'h41 : 7'h40;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   assign rise = scl && !scl_q;
   assign pull = sda_s_oe && !sda_s_o;
   assign mpull = sda_m_oe && !sda_m_o;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
         rd_q <= 1'b0;
         hit_q <= 1'b0;
         idle_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start || stop) begin
            cnt_q <= 4'h0;
            byte_q <= 2'h0;
            rd_q <= 1'b0;
            idle_q <= stop;
         end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h8 && byte_q != 2'h3) begin
               byte_q <= byte_q + 2'h1;
            end
            if (cnt_q == 4'h8 && byte_q == 2'h0) begin
               hit_q <= (sh_q[7:1] == own);
               rd_q <= sh_q[0] && (sh_q[7:1] == own);
            end
         end
      end
   end
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      (scl && sda) ##1 (scl && !sda);
   endsequence
   sequence s_ninth;
      rise && cnt_q == 4'h8;
   endsequence
   start_release_a: assert property (s_start |-> !pull [*4])
      else $error("device pulls data line after start");
   sda_stable_a: assert property (scl |-> $stable(pull))
      else $error("device changed data line while clock high");
   addr_ack_a: assert property (s_ninth ##0 byte_q == 2'h0 |-> sda == (sh_q[7:1] != own))
      else $error("address acknowledge wrong");
   data_ack_a: assert property (s_ninth ##0 (byte_q != 2'h0 && hit_q && !rd_q) |-> !sda)
      else $error("written byte not acknowledged");
   foreign_quiet_a: assert property (byte_q != 2'h0 && !hit_q |-> !pull)
      else $error("device drives after foreign address");
   idle_quiet_a: assert property (idle_q |-> !pull)
      else $error("device drives after stop");
   slot_only_a: assert property (pull && scl && scl_q |-> byte_q != 2'h0 && (cnt_q == 4'h0 || rd_q))
      else $error("device drives outside its slots");
   master_release_a: assert property (s_ninth ##0 (byte_q == 2'h0 || !rd_q) |-> !mpull)
      else $error("master holds data line in acknowledge slot");
   // The first clock of a byte may carry a stop or repeated start set up by the master.
   read_release_a: assert property (rise && cnt_q != 4'h0 && cnt_q < 4'h8 && rd_q
      && byte_q != 2'h0 |-> !mpull)
      else $error("master drives during read data");
endmodule

// [tb/tb_led_driver_i2c_register_slave.sv]
`timescale 1ns/1ps
module tb_led_driver_i2c_register_slave;
   logic clk, rst_n, addr_strap, cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_nack;
   logic res_valid, res_ack, wr_stb, a;
   logic [7:0] cmd_data, res_data, wr_data, rd_data, q;
   logic [4:0] wr_idx, rd_idx;
   logic [7:0] mem [32];
   logic [12:0] wq [$];
   int error_cnt, num_checks, cyc;
   ldi2c_if bus_if ();
   ldi2c_host ldi2c_host_i (.clk(clk), .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
      .cmd_nack(cmd_nack), .cmd_data(cmd_data), .res_valid(res_valid), .res_data(res_data),
      .res_ack(res_ack));
   ldi2c_device ldi2c_device_i (.clk(clk), .rst_n(rst_n), .bus(bus_if), .scl_clk(bus_if.scl),
      .addr_strap(addr_strap), .wr_stb(wr_stb), .wr_idx(wr_idx), .wr_data(wr_data),
      .rd_idx(rd_idx), .rd_data(rd_data));
   ldi2c_checker ldi2c_checker_i (.clk(clk), .rst_n(rst_n), .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
      .sda_s_oe(bus_if.sda_s_oe), .addr_strap(addr_strap));
   // The bench plays the internal logic: reads come from a fixed table.
   assign rd_data = mem[rd_idx];
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wr_stb === 1'b1) wq.push_back({wr_idx, wr_data});
      if (cyc == 30000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ********************
   // Tasks
   // ********************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Flags are start, stop, read, nack; entered just after a rising edge.
   task automatic xfer(input logic [3:0] f, input logic [7:0] d);
      int k;
      k = 0;
      {cmd_start, cmd_stop, cmd_read, cmd_nack} <= f;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      do @(negedge clk); while (cmd_ready !== 1'b1);
      @(posedge clk);
      cmd_valid <= 1'b0;
      do begin
         @(negedge clk);
         k++;
      end while (res_valid !== 1'b1 && k < 2000);
      if (res_valid !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      q = res_data;
      a = res_ack;
      @(posedge clk);
   endtask
   task automatic wr_burst(input logic [6:0] dev, input logic [7:0] idx, b0, b1, input logic e);
      xfer(4'h8, {dev, 1'b0});
      check("address ack", {12'h000, a}, {12'h000, e});
      xfer(4'h0, idx);
      check("index ack", {12'h000, a}, {12'h000, e});
      xfer(4'h0, b0);
      check("data ack", {12'h000, a}, {12'h000, e});
      xfer(4'h4, b1);
      check("last ack", {12'h000, a}, {12'h000, e});
   endtask
   task automatic settle(input int n);
      int k;
      k = 0;
      while (wq.size() < n && k < 300) begin
         @(posedge clk);
         k++;
      end
   endtask
   // ********************
   // Main sequence
   // ********************
   initial begin
      rst_n = 1'b0;
      addr_strap = 1'b0;
      cmd_valid = 1'b0;
      {cmd_start, cmd_stop, cmd_read, cmd_nack} = 4'h0;
      cmd_data = 8'h00;
      cyc = 0;
      for (int i = 0; i < 32; i++) mem[i] = 8'h5a ^ 8'(i);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wr_burst(7'h40, 8'h02, 8'h12, 8'h34, 1'b1);
      settle(2);
      check("write count", 13'(wq.size()), 13'h0002);
      check("first write", wq.pop_front(), {5'h02, 8'h12});
      check("second write", wq.pop_front(), {5'h03, 8'h34});
      $display("write burst test done");
      xfer(4'h8, 8'h80);
      xfer(4'h0, 8'h1e);
      xfer(4'h8, 8'h81);
      check("read address ack", {12'h000, a}, 13'h0001);
      xfer(4'h2, 8'hff);
      check("read first", {5'h00, q}, {5'h00, mem[30]});
      xfer(4'h7, 8'hff);
      check("read next", {5'h00, q}, {5'h00, mem[31]});
      $display("read burst test done");
      wr_burst(7'h42, 8'h04, 8'h55, 8'h66, 1'b0);
      settle(1);
      check("foreign writes", 13'(wq.size()), 13'h0000);
      $display("foreign address test done");
      rst_n <= 1'b0;
      addr_strap <= 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wr_burst(7'h40, 8'h08, 8'h77, 8'h88, 1'b0);
      wr_burst(7'h41, 8'h08, 8'h99, 8'haa, 1'b1);
      settle(2);
      check("strap write count", 13'(wq.size()), 13'h0002);
      check("strap write", wq.pop_front(), {5'h08, 8'h99});
      $display("strap test done");
      stop_test();
   end
endmodule
